// >>> src/isb_pkg.sv
// package of the interpolation set-point block: object addresses,
// reset presets and the request carrier
// assumes a single controller clock domain
package isb_pkg;

  // ----------------------------------------------------------------
  // object addresses (index, subindex)
  // ----------------------------------------------------------------
  localparam logic [15:0] IDX_SETPOINT = 16'h60C1;
  localparam logic [15:0] IDX_PERIOD   = 16'h60C2;
  localparam logic [15:0] IDX_BUF_CFG  = 16'h60C4;
  localparam logic [15:0] IDX_ACCEL    = 16'h60C5;
  localparam logic [15:0] IDX_DECEL    = 16'h60C6;
  localparam logic [15:0] IDX_FB_POS   = 16'h60E4;

  localparam logic [7:0] SUB_COUNT    = 8'h00;
  localparam logic [7:0] SUB_FIRST    = 8'h01;
  localparam logic [7:0] SUB_P_VALUE  = 8'h01;
  localparam logic [7:0] SUB_P_EXP    = 8'h02;
  localparam logic [7:0] SUB_CAPACITY = 8'h01;
  localparam logic [7:0] SUB_FILL     = 8'h02;
  localparam logic [7:0] SUB_LAYOUT   = 8'h03;
  localparam logic [7:0] SUB_WPTR     = 8'h04;
  localparam logic [7:0] SUB_RECSIZE  = 8'h05;
  localparam logic [7:0] SUB_PURGE    = 8'h06;

  // ----------------------------------------------------------------
  // presets and encodings
  // ----------------------------------------------------------------
  localparam logic [7:0]  SETPOINT_CNT_RST = 8'h01;
  localparam logic [31:0] SETPOINT_RST     = 32'h00000000;
  localparam logic [7:0]  PERIOD_CNT_RST   = 8'h02;
  localparam logic [7:0]  PERIOD_VAL_RST   = 8'h01;
  localparam logic [7:0]  PERIOD_EXP_RST   = 8'hFD;
  localparam logic [7:0]  PERIOD_EXP_MS    = 8'hFD;
  localparam logic [7:0]  BUF_CFG_CNT_RST  = 8'h06;
  localparam logic [31:0] CAPACITY_RST     = 32'h00000001;
  localparam logic [31:0] FILL_RST         = 32'h00000001;
  localparam logic [7:0]  LAYOUT_RST       = 8'h00;
  localparam logic [15:0] WPTR_RST         = 16'h0001;
  localparam logic [7:0]  RECSIZE_RST      = 8'h04;
  localparam logic [7:0]  PURGE_CLEAR      = 8'h00;
  localparam logic [7:0]  PURGE_ENABLE     = 8'h01;
  localparam logic [31:0] ACCEL_RST        = 32'h00001388;
  localparam logic [31:0] DECEL_RST        = 32'h00001388;
  localparam logic [7:0]  FB_CNT_RST       = 8'h03;

  typedef enum logic [7:0] {
    ISB_LAYOUT_FIFO = 8'h00,
    ISB_LAYOUT_RING = 8'h01
  } isb_layout_e;

  // one object-dictionary access
  typedef struct packed {
    logic        wr;
    logic [15:0] index;
    logic [7:0]  sub;
    logic [31:0] wdata;
  } isb_req_s;

  // answer to one access
  typedef struct packed {
    logic        err;
    logic [31:0] rdata;
  } isb_rsp_s;

endpackage

// >>> src/isb_setpoint_buffer.sv
// interpolated-position parameter block with set-point buffer
// assumes od accesses and feedback positions come from core_clk logic;
// sync_in is an asynchronous pin
`timescale 1ns/1ps

module isb_setpoint_buffer #(
  parameter int DEPTH    = 2,
  parameter int CAPACITY = 1,
  parameter int NUM_FB   = 3
) (
  input  wire logic                      core_clk,
  input  wire logic                      rst_n,
  input  wire logic                      od_valid,
  input  isb_pkg::isb_req_s              od_req,
  output logic                           od_ready,
  output logic                           od_ack,
  output isb_pkg::isb_rsp_s              od_rsp,
  input  wire logic                      sync_in,
  output logic                           demand_valid,
  input  wire logic                      demand_ready,
  output logic signed [31:0]             demand_pos,
  output logic [31:0]                    cycle_time_us,
  output logic                           period_exp_bad,
  output logic [31:0]                    accel_limit,
  output logic [31:0]                    decel_limit,
  output logic [7:0]                     record_size_bytes,
  output logic                           buffer_enabled,
  input  wire logic signed [NUM_FB-1:0][31:0] fb_pos
);

  localparam int IW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] CAP_C = CW'(CAPACITY);

  // ----------------------------------------------------------------
  // sync pin: three flops, edge counted when stages two and three agree
  // ----------------------------------------------------------------
  logic sync_s1_q;
  logic sync_s2_q;
  logic sync_s3_q;
  logic sync_lvl_q;
  logic sync_pulse;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_s1_q <= 1'b0;
      sync_s2_q <= 1'b0;
      sync_s3_q <= 1'b0;
    end else begin
      sync_s1_q <= sync_in;
      sync_s2_q <= sync_s1_q;
      sync_s3_q <= sync_s2_q;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_lvl_q <= 1'b0;
    end else if (sync_s2_q == sync_s3_q) begin
      sync_lvl_q <= sync_s3_q;
    end
  end

  assign sync_pulse = (sync_s2_q == sync_s3_q) && sync_s3_q && !sync_lvl_q;

  // ----------------------------------------------------------------
  // access decode
  // ----------------------------------------------------------------
  logic take;
  logic wr_take;
  logic sp_wr;
  logic cap_full;
  logic layout_ring;
  logic push;
  logic pop;
  logic purge_clr;
  logic purge_en;
  logic fill_clr;
  logic wptr_wr;

  logic [7:0]  layout_q;
  logic [15:0] wptr_q;
  logic [7:0]  p_val_q;
  logic [7:0]  p_exp_q;
  logic        en_q;
  logic [CW-1:0] count_q;
  logic [IW-1:0] rd_idx_q;
  logic [IW-1:0] wr_idx_q;
  logic signed [31:0] buf_q [DEPTH];

  assign layout_ring = (layout_q == isb_pkg::ISB_LAYOUT_RING);
  assign cap_full    = (count_q >= CAP_C) || (count_q == CW'(DEPTH));
  assign sp_wr = od_req.wr && (od_req.index == isb_pkg::IDX_SETPOINT)
                 && (od_req.sub == isb_pkg::SUB_FIRST);

  // a full fifo stalls the master; a ring overwrites its oldest record
  assign od_ready = !(sp_wr && en_q && cap_full && !layout_ring && !pop);
  assign take     = od_valid && od_ready;
  assign wr_take  = take && od_req.wr;
  assign push     = take && sp_wr && en_q;
  assign pop      = sync_pulse && (count_q != '0) && !demand_valid;

  assign purge_clr = wr_take && (od_req.index == isb_pkg::IDX_BUF_CFG)
                     && (od_req.sub == isb_pkg::SUB_PURGE)
                     && (od_req.wdata[7:0] == isb_pkg::PURGE_CLEAR);
  assign purge_en  = wr_take && (od_req.index == isb_pkg::IDX_BUF_CFG)
                     && (od_req.sub == isb_pkg::SUB_PURGE)
                     && (od_req.wdata[7:0] == isb_pkg::PURGE_ENABLE);
  assign fill_clr  = wr_take && (od_req.index == isb_pkg::IDX_BUF_CFG)
                     && (od_req.sub == isb_pkg::SUB_FILL)
                     && (od_req.wdata == 32'h00000000);
  assign wptr_wr   = wr_take && (od_req.index == isb_pkg::IDX_BUF_CFG)
                     && (od_req.sub == isb_pkg::SUB_WPTR);

  function automatic logic [IW-1:0] nxt(input logic [IW-1:0] i);
    nxt = (32'(i) >= DEPTH - 1) ? '0 : IW'(32'(i) + 1);
  endfunction

  // ----------------------------------------------------------------
  // access enable and buffer storage
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      en_q <= 1'b1;
    end else if (purge_clr) begin
      en_q <= 1'b0;
    end else if (purge_en) begin
      en_q <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        buf_q[i] <= isb_pkg::SETPOINT_RST;
      end
    end else if (push) begin
      buf_q[wr_idx_q] <= od_req.wdata;
    end
  end

  // drop the oldest record when a ring push meets a full buffer
  logic ring_drop;
  assign ring_drop = push && cap_full && layout_ring && !pop;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_idx_q <= '0;
      wr_idx_q <= IW'(1 % DEPTH);
      count_q  <= CW'(isb_pkg::FILL_RST);
    end else if (purge_clr || fill_clr) begin
      rd_idx_q <= '0;
      wr_idx_q <= '0;
      count_q  <= '0;
    end else begin
      if (push) begin
        wr_idx_q <= nxt(wr_idx_q);
      end
      if (pop || ring_drop) begin
        rd_idx_q <= nxt(rd_idx_q);
      end
      if (push && !pop && !ring_drop) begin
        count_q <= count_q + CW'(1);
      end else if (pop && !push) begin
        count_q <= count_q - CW'(1);
      end
    end
  end

  // next free slot, one-based, wraps at the capacity
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wptr_q <= isb_pkg::WPTR_RST;
    end else if (purge_clr) begin
      wptr_q <= 16'h0000;
    end else if (purge_en) begin
      wptr_q <= isb_pkg::WPTR_RST;
    end else if (!en_q) begin
      wptr_q <= 16'h0000;
    end else if (wptr_wr) begin
      wptr_q <= od_req.wdata[15:0];
    end else if (push) begin
      wptr_q <= (32'(wptr_q) >= CAPACITY) ? 16'h0001 : wptr_q + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // demand output, taken over only at a sync instant
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      demand_pos   <= isb_pkg::SETPOINT_RST;
      demand_valid <= 1'b0;
    end else begin
      if (pop) begin
        demand_pos   <= buf_q[rd_idx_q];
        demand_valid <= 1'b1;
      end else if (demand_ready) begin
        demand_valid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // period, limits, layout and record size
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      p_val_q <= isb_pkg::PERIOD_VAL_RST;
      p_exp_q <= isb_pkg::PERIOD_EXP_RST;
    end else if (wr_take && od_req.index == isb_pkg::IDX_PERIOD) begin
      if (od_req.sub == isb_pkg::SUB_P_VALUE) begin
        p_val_q <= od_req.wdata[7:0];
      end
      if (od_req.sub == isb_pkg::SUB_P_EXP) begin
        p_exp_q <= od_req.wdata[7:0];
      end
    end
  end

  // power of ten scaled to microseconds; exponents outside -6..0 give 0
  function automatic logic [31:0] pow10_us(input logic signed [7:0] e);
    unique case (e)
      -8'sd6:  pow10_us = 32'h00000001;
      -8'sd5:  pow10_us = 32'h0000000A;
      -8'sd4:  pow10_us = 32'h00000064;
      -8'sd3:  pow10_us = 32'h000003E8;
      -8'sd2:  pow10_us = 32'h00002710;
      -8'sd1:  pow10_us = 32'h000186A0;
      8'sd0:   pow10_us = 32'h000F4240;
      default: pow10_us = 32'h00000000;
    endcase
  endfunction

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cycle_time_us  <= 32'h00000000;
      period_exp_bad <= 1'b0;
    end else begin
      cycle_time_us  <= 32'({24'h000000, p_val_q} * pow10_us(p_exp_q));
      period_exp_bad <= (p_exp_q != isb_pkg::PERIOD_EXP_MS);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      accel_limit <= isb_pkg::ACCEL_RST;
      decel_limit <= isb_pkg::DECEL_RST;
    end else if (wr_take && od_req.sub == isb_pkg::SUB_COUNT) begin
      if (od_req.index == isb_pkg::IDX_ACCEL) begin
        accel_limit <= od_req.wdata;
      end
      if (od_req.index == isb_pkg::IDX_DECEL) begin
        decel_limit <= od_req.wdata;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      layout_q          <= isb_pkg::LAYOUT_RST;
      record_size_bytes <= isb_pkg::RECSIZE_RST;
    end else if (wr_take && od_req.index == isb_pkg::IDX_BUF_CFG) begin
      if (od_req.sub == isb_pkg::SUB_LAYOUT) begin
        layout_q <= od_req.wdata[7:0];
      end
      if (od_req.sub == isb_pkg::SUB_RECSIZE) begin
        record_size_bytes <= od_req.wdata[7:0];
      end
    end
  end

  assign buffer_enabled = en_q;

  // ----------------------------------------------------------------
  // read mux and answer
  // ----------------------------------------------------------------
  isb_pkg::isb_rsp_s rsp_d;
  logic [7:0] fb_sub;
  assign fb_sub = od_req.sub;

  always_comb begin
    rsp_d = '{err: 1'b0, rdata: 32'h00000000};
    unique case (od_req.index)
      isb_pkg::IDX_SETPOINT: begin
        if (od_req.sub == isb_pkg::SUB_COUNT) begin
          rsp_d.err   = od_req.wr;
          rsp_d.rdata = {24'h000000, isb_pkg::SETPOINT_CNT_RST};
        end else if (od_req.sub == isb_pkg::SUB_FIRST) begin
          rsp_d.rdata = (count_q != '0) ? buf_q[rd_idx_q] : demand_pos;
        end else begin
          rsp_d.err = 1'b1;
        end
      end
      isb_pkg::IDX_PERIOD: begin
        unique case (od_req.sub)
          isb_pkg::SUB_COUNT: begin
            rsp_d.err   = od_req.wr;
            rsp_d.rdata = {24'h000000, isb_pkg::PERIOD_CNT_RST};
          end
          isb_pkg::SUB_P_VALUE: rsp_d.rdata = {24'h000000, p_val_q};
          isb_pkg::SUB_P_EXP:   rsp_d.rdata = {{24{p_exp_q[7]}}, p_exp_q};
          default:              rsp_d.err = 1'b1;
        endcase
      end
      isb_pkg::IDX_BUF_CFG: begin
        unique case (od_req.sub)
          isb_pkg::SUB_COUNT: begin
            rsp_d.err   = od_req.wr;
            rsp_d.rdata = {24'h000000, isb_pkg::BUF_CFG_CNT_RST};
          end
          isb_pkg::SUB_CAPACITY: begin
            rsp_d.err   = od_req.wr;
            rsp_d.rdata = 32'(CAPACITY);
          end
          isb_pkg::SUB_FILL:   rsp_d.rdata = 32'(count_q);
          isb_pkg::SUB_LAYOUT: rsp_d.rdata = {24'h000000, layout_q};
          isb_pkg::SUB_WPTR:   rsp_d.rdata = {16'h0000, wptr_q};
          isb_pkg::SUB_RECSIZE: rsp_d.err = !od_req.wr;
          isb_pkg::SUB_PURGE:   rsp_d.err = !od_req.wr;
          default:              rsp_d.err = 1'b1;
        endcase
      end
      isb_pkg::IDX_ACCEL: begin
        rsp_d.err   = (od_req.sub != isb_pkg::SUB_COUNT);
        rsp_d.rdata = accel_limit;
      end
      isb_pkg::IDX_DECEL: begin
        rsp_d.err   = (od_req.sub != isb_pkg::SUB_COUNT);
        rsp_d.rdata = decel_limit;
      end
      isb_pkg::IDX_FB_POS: begin
        rsp_d.err = od_req.wr;
        if (fb_sub == isb_pkg::SUB_COUNT) begin
          rsp_d.rdata = 32'(NUM_FB);
        end else if (32'(fb_sub) <= NUM_FB) begin
          rsp_d.rdata = fb_pos[IW'(0) + (fb_sub - 8'h01)];
        end else begin
          rsp_d.err = 1'b1;
        end
      end
      default: rsp_d.err = 1'b1;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      od_ack <= 1'b0;
      od_rsp <= '{err: 1'b0, rdata: 32'h00000000};
    end else begin
      od_ack <= take;
      if (take) begin
        od_rsp <= rsp_d;
      end
    end
  end

endmodule

// >>> verification/isb_setpoint_buffer_monitor.sv
// port checks for the interpolation set-point block
// assumes it is bound to isb_setpoint_buffer, one core_clk domain
`timescale 1ns/1ps
module isb_setpoint_buffer_monitor (
  input wire logic               core_clk,
  input wire logic               rst_n,
  input wire logic               od_valid,
  input isb_pkg::isb_req_s       od_req,
  input wire logic               od_ready,
  input wire logic               od_ack,
  input wire logic               sync_in,
  input wire logic               demand_valid,
  input wire logic               demand_ready,
  input wire logic signed [31:0] demand_pos,
  input wire logic [31:0]        accel_limit,
  input wire logic [31:0]        decel_limit,
  input wire logic [7:0]         record_size_bytes,
  input wire logic               buffer_enabled
);
  // ----------------------------------------------------------------
  // helper logic
  // ----------------------------------------------------------------
  logic       take;
  logic       wr_on;
  logic       sync_prev_q;
  logic [3:0] since_sync_q;
  assign take = od_valid && od_ready;
  assign wr_on = take && od_req.wr;
  // cycles since the sync pin last rose, saturating
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_prev_q  <= 1'b0;
      since_sync_q <= 4'hF;
    end else begin
      sync_prev_q <= sync_in;
      if (sync_in && !sync_prev_q) begin
        since_sync_q <= 4'h0;
      end else if (since_sync_q != 4'hF) begin
        since_sync_q <= since_sync_q + 4'h1;
      end
    end
  end
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  chk_ack_after_take:
    assert property (take |=> od_ack) else $error("ack missing");
  chk_ack_has_cause:
    assert property (od_ack |-> $past(take)) else $error("stray ack");
  chk_stall_cause:
    assert property (od_valid && !od_ready |-> od_req.wr && buffer_enabled
      && od_req.index == isb_pkg::IDX_SETPOINT) else $error("bad refusal");
  chk_demand_on_sync:
    assert property ($rose(demand_valid) |-> since_sync_q inside {[2:7]})
    else $error("demand without sync");
  chk_demand_holds:
    assert property (demand_valid && !demand_ready |=> demand_valid
      && $stable(demand_pos)) else $error("demand dropped");
  chk_recsize_set:
    assert property (wr_on && od_req.index == isb_pkg::IDX_BUF_CFG
      && od_req.sub == isb_pkg::SUB_RECSIZE |=> record_size_bytes
      == $past(od_req.wdata[7:0])) else $error("record size not set");
  chk_accel_set:
    assert property (wr_on && od_req.index == isb_pkg::IDX_ACCEL
      && od_req.sub == isb_pkg::SUB_COUNT |=> accel_limit
      == $past(od_req.wdata)) else $error("accel not set");
  chk_decel_set:
    assert property (wr_on && od_req.index == isb_pkg::IDX_DECEL
      && od_req.sub == isb_pkg::SUB_COUNT |=> decel_limit
      == $past(od_req.wdata)) else $error("decel not set");
  chk_purge_off:
    assert property (wr_on && od_req.index == isb_pkg::IDX_BUF_CFG
      && od_req.sub == isb_pkg::SUB_PURGE && od_req.wdata[7:0] == 8'h00
      |=> !buffer_enabled) else $error("purge did not disable");
  chk_purge_on:
    assert property (wr_on && od_req.index == isb_pkg::IDX_BUF_CFG
      && od_req.sub == isb_pkg::SUB_PURGE && od_req.wdata[7:0] == 8'h01
      |=> buffer_enabled) else $error("purge did not enable");
endmodule

bind isb_setpoint_buffer isb_setpoint_buffer_monitor chk_u (
  .core_clk(core_clk), .rst_n(rst_n), .od_valid(od_valid),
  .od_req(od_req), .od_ready(od_ready), .od_ack(od_ack),
  .sync_in(sync_in), .demand_valid(demand_valid),
  .demand_ready(demand_ready), .demand_pos(demand_pos),
  .accel_limit(accel_limit), .decel_limit(decel_limit),
  .record_size_bytes(record_size_bytes), .buffer_enabled(buffer_enabled)
);

// >>> verification/isb_master_model.sv
// master side model: drives the sync pin and consumes demands
// assumes the bench calls sync_pulse and sets stall_en off the rising edge
`timescale 1ns/1ps
module isb_master_model (
  input  wire logic core_clk,
  input  wire logic stall_en,
  output logic      sync_in,
  output logic      demand_ready
);
  int seed = 35;
  initial sync_in = 1'b0;
  initial demand_ready = 1'b1;
  // consumer stalls at random when asked to
  always @(negedge core_clk) begin
    demand_ready <= !stall_en || ($random(seed) & 1) != 0;
  end
  // one sync instant: pin high four cycles, low outside
  task automatic sync_pulse();
    @(negedge core_clk);
    sync_in = 1'b1;
    repeat (4) @(negedge core_clk);
    sync_in = 1'b0;
  endtask
endmodule

// >>> verification/tb.sv
// self-checking bench of the interpolation set-point block
// assumes the monitor is bound and the master model drives sync and ready
`timescale 1ns/1ps
module tb;
  logic                    core_clk = 1'b0;
  logic                    rst_n = 1'b0;
  logic                    od_valid = 1'b0;
  isb_pkg::isb_req_s       od_req = '0;
  logic signed [2:0][31:0] fb_pos = '0;
  logic                    stall_en = 1'b0;
  logic                    od_ready, od_ack, sync_in, demand_valid;
  logic                    demand_ready, period_exp_bad, buffer_enabled;
  isb_pkg::isb_rsp_s       od_rsp;
  logic signed [31:0]      demand_pos;
  logic [31:0]             cycle_time_us, accel_limit, decel_limit, v, w;
  logic [7:0]              record_size_bytes;
  isb_pkg::isb_rsp_s       rsp_q[$];
  bit                      rd_q[$];
  logic [31:0]             dem_q[$];
  int                      err_total = 0;
  int                      tests_run = 0;
  int                      seed = 35;
  logic [55:0]             rst_tab [13] = '{
    56'h60C1_00_00000001, 56'h60C1_01_00000000, 56'h60C2_00_00000002,
    56'h60C2_01_00000001, 56'h60C2_02_FFFFFFFD, 56'h60C4_00_00000006,
    56'h60C4_01_00000001, 56'h60C4_02_00000001, 56'h60C4_03_00000000,
    56'h60C4_04_00000001, 56'h60C5_00_00001388, 56'h60C6_00_00001388,
    56'h60E4_00_00000003};
  always #4 core_clk = ~core_clk;
  isb_setpoint_buffer #(.DEPTH(2), .CAPACITY(1), .NUM_FB(3)) dut_u (
    .core_clk(core_clk), .rst_n(rst_n), .od_valid(od_valid),
    .od_req(od_req), .od_ready(od_ready), .od_ack(od_ack),
    .od_rsp(od_rsp), .sync_in(sync_in), .demand_valid(demand_valid),
    .demand_ready(demand_ready), .demand_pos(demand_pos),
    .cycle_time_us(cycle_time_us), .period_exp_bad(period_exp_bad),
    .accel_limit(accel_limit), .decel_limit(decel_limit),
    .record_size_bytes(record_size_bytes),
    .buffer_enabled(buffer_enabled), .fb_pos(fb_pos));
  isb_master_model master_u (.core_clk(core_clk), .stall_en(stall_en),
    .sync_in(sync_in), .demand_ready(demand_ready));
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic cmp(string what, logic [31:0] exp, logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cmp_rsp(string what, logic [31:0] exp, logic [31:0] got);
    cmp(what, exp, got);
  endtask
  task automatic cmp_dem(string what, logic [31:0] exp, logic [31:0] got);
    cmp(what, exp, got);
  endtask
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic od(bit wr, logic [15:0] idx, logic [7:0] sub,
      logic [31:0] wd, bit err, logic [31:0] rd);
    int n;
    rsp_q.push_back({err, rd});
    rd_q.push_back(!wr && !err);
    @(negedge core_clk);
    od_valid = 1'b1;
    od_req = {wr, idx, sub, wd};
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (od_ready !== 1'b1 && n < 60);
    if (od_ready !== 1'b1) cmp("od_ready", 32'h1, {31'h0, od_ready});
    @(negedge core_clk);
    od_valid = 1'b0;
  endtask
  task automatic sync_pop(logic [31:0] exp);
    int n;
    dem_q.push_back(exp);
    master_u.sync_pulse();
    for (n = 0; dem_q.size() != 0 && n < 100; n++) @(negedge core_clk);
    cmp("demand_pending", 32'h0, dem_q.size());
  endtask
  // results are matched against the oldest note as they appear
  always @(posedge core_clk) begin
    if (od_ack === 1'b1) begin
      cmp_rsp("od_rsp_err", rsp_q.size() ? rsp_q[0].err : 1'bx,
        od_rsp.err);
      if (rsp_q.size() && rd_q[0]) begin
        cmp_rsp("od_rdata", rsp_q[0].rdata, od_rsp.rdata);
      end
      if (rsp_q.size()) void'(rsp_q.pop_front());
      if (rd_q.size()) void'(rd_q.pop_front());
    end
    if (demand_valid === 1'b1 && demand_ready === 1'b1) begin
      cmp_dem("demand_pos", dem_q.size() ? dem_q[0] : 'x, demand_pos);
      if (dem_q.size()) void'(dem_q.pop_front());
    end
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    cmp("watchdog", 32'h0, 32'h1);
    end_sim();
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge core_clk);
    @(negedge core_clk);
    rst_n = 1'b1;
    cmp("record_size_bytes", 32'h4, {24'h0, record_size_bytes});
    cmp("buffer_enabled", 32'h1, {31'h0, buffer_enabled});
    @(negedge core_clk);
    cmp("cycle_time_us", 32'h3E8, cycle_time_us);
    cmp("period_exp_bad", 32'h0, {31'h0, period_exp_bad});
    foreach (rst_tab[k]) od(1'b0, rst_tab[k][55:40], rst_tab[k][39:32],
      32'h0, 1'b0, rst_tab[k][31:0]);
    od(1'b0, 16'h60C4, 8'h05, 32'h0, 1'b1, 32'h0);
    od(1'b0, 16'h60C4, 8'h06, 32'h0, 1'b1, 32'h0);
    od(1'b1, 16'h60C4, 8'h01, 32'h7, 1'b1, 32'h0);
    od(1'b0, 16'h60C4, 8'h01, 32'h0, 1'b0, 32'h1);
    od(1'b1, 16'h60E4, 8'h00, 32'h9, 1'b1, 32'h0);
    for (int k = 0; k < 3; k++) fb_pos[k] = $random(seed);
    for (int k = 0; k < 3; k++)
      od(1'b0, 16'h60E4, 8'(k + 1), 32'h0, 1'b0, fb_pos[k]);
    od(1'b1, 16'h60C2, 8'h01, 32'h5, 1'b0, 32'h0);
    od(1'b1, 16'h60C2, 8'h02, 32'hFE, 1'b0, 32'h0);
    repeat (4) @(negedge core_clk);
    cmp("cycle_time_us", 32'hC350, cycle_time_us);
    cmp("period_exp_bad", 32'h1, {31'h0, period_exp_bad});
    od(1'b1, 16'h60C2, 8'h02, 32'hFD, 1'b0, 32'h0);
    repeat (4) @(negedge core_clk);
    cmp("cycle_time_us", 32'h1388, cycle_time_us);
    v = $random(seed);
    od(1'b1, 16'h60C5, 8'h00, v, 1'b0, 32'h0);
    od(1'b0, 16'h60C5, 8'h00, 32'h0, 1'b0, v);
    od(1'b1, 16'h60C6, 8'h00, ~v, 1'b0, 32'h0);
    od(1'b0, 16'h60C6, 8'h00, 32'h0, 1'b0, ~v);
    od(1'b1, 16'h60C4, 8'h05, 32'h8, 1'b0, 32'h0);
    cmp("record_size_bytes", 32'h8, {24'h0, record_size_bytes});
    stall_en = 1'b1;
    sync_pop(32'h0);
    od(1'b0, 16'h60C4, 8'h02, 32'h0, 1'b0, 32'h0);
    v = $random(seed);
    w = $random(seed);
    od(1'b1, 16'h60C1, 8'h01, v, 1'b0, 32'h0);
    od(1'b0, 16'h60C4, 8'h02, 32'h0, 1'b0, 32'h1);
    repeat (8) @(negedge core_clk);
    fork
      od(1'b1, 16'h60C1, 8'h01, w, 1'b0, 32'h0);
      begin
        repeat (6) @(negedge core_clk);
        sync_pop(v);
      end
    join
    od(1'b1, 16'h60C4, 8'h03, 32'h1, 1'b0, 32'h0);
    od(1'b0, 16'h60C4, 8'h03, 32'h0, 1'b0, 32'h1);
    v = $random(seed);
    od(1'b1, 16'h60C1, 8'h01, v, 1'b0, 32'h0);
    od(1'b0, 16'h60C4, 8'h02, 32'h0, 1'b0, 32'h1);
    sync_pop(v);
    od(1'b1, 16'h60C4, 8'h03, 32'h0, 1'b0, 32'h0);
    od(1'b1, 16'h60C1, 8'h01, w, 1'b0, 32'h0);
    od(1'b1, 16'h60C4, 8'h06, 32'h0, 1'b0, 32'h0);
    cmp("buffer_enabled", 32'h0, {31'h0, buffer_enabled});
    od(1'b0, 16'h60C4, 8'h02, 32'h0, 1'b0, 32'h0);
    od(1'b0, 16'h60C4, 8'h04, 32'h0, 1'b0, 32'h0);
    od(1'b1, 16'h60C1, 8'h01, v, 1'b0, 32'h0);
    od(1'b0, 16'h60C4, 8'h02, 32'h0, 1'b0, 32'h0);
    master_u.sync_pulse();
    repeat (12) @(negedge core_clk);
    od(1'b1, 16'h60C4, 8'h06, 32'h1, 1'b0, 32'h0);
    cmp("buffer_enabled", 32'h1, {31'h0, buffer_enabled});
    od(1'b0, 16'h60C4, 8'h04, 32'h0, 1'b0, 32'h1);
    repeat (4) @(negedge core_clk);
    end_sim();
  end
endmodule
